/* dv/mpio_pad.sv */
// Board model: pull-up pads with an optional external pull-low per pin.
// Assumes out and oe of mpio_top; a high oe drives the pin.
module mpio_pad #(parameter W = 8) (
  // From the block
  input wire [W-1:0] out,
  input wire [W-1:0] oe,
  // From the bench
  input wire [W-1:0] ext_low,
  // To the block
  output wire [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pins show the block's level, released ones the pull-up
  assign pin = (oe & out | ~oe) & ~ext_low;
endmodule

/* dv/mpio_top_properties.sv */
// Checker for mpio_top: APB timing and pin drive relations.
// Assumes the offsets and control fields of mpio_defs.vh.
`include "mpio_defs.vh"
module mpio_props (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pins
  input wire [2:0] port_b_oe,
  input wire [3:0] port_c_out,
  input wire [3:0] port_c_oe,
  input wire slow_crystal_en,
  input wire ext_irq_latch
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [2:0] ctrl_r;
  reg [3:0] type_r;
  reg [1:0] quiet_r;
  reg b0_r;
  wire wr = psel & penable & pready & pwrite;
  wire fall = wr & paddr == `MPIO_B_LATCH & b0_r & !pwdata[0] & ctrl_r[2] & !ctrl_r[1];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mirror control, output type and port_b bit 0; count quiet cycles after a write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 3'h0;
      type_r <= 4'h0;
      quiet_r <= 2'h0;
      b0_r <= 1'b1;
    end else begin
      quiet_r <= wr ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
      if (wr && paddr == `MPIO_CTRL) ctrl_r <= pwdata[2:0];
      if (wr && paddr == `MPIO_C_TYPE) type_r <= pwdata[3:0];
      if (wr && paddr == `MPIO_B_LATCH) b0_r <= pwdata[0];
    end
  end
  property p_rdy; psel && $rose(penable) |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("prdata outside answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_bw; pready && !pwrite && paddr == `MPIO_B_LATCH |-> prdata[31:3] == 29'h0; endproperty
  a_bw: assert property (p_bw) else $error("port_b upper read bits");
  property p_xtal; quiet_r == 2'h3 |-> slow_crystal_en == ctrl_r[0]; endproperty
  a_xtal: assert property (p_xtal) else $error("crystal enable");
  property p_irq; fall |-> ##[0:3] ext_irq_latch; endproperty
  a_irq: assert property (p_irq) else $error("interrupt latch not set");
  property p_stop; quiet_r == 2'h3 && ctrl_r[1] |-> !port_b_oe[0]; endproperty
  a_stop: assert property (p_stop) else $error("pin0 driven in stop");
  property p_type; quiet_r == 2'h3 && ctrl_r[2] |-> port_c_oe == (type_r | ~port_c_out); endproperty
  a_type: assert property (p_type) else $error("port_c driver type");
  property p_off; quiet_r == 2'h3 && !ctrl_r[2] |-> port_b_oe == 3'h0 && port_c_oe == 4'h0; endproperty
  a_off: assert property (p_off) else $error("pins driven while disabled");
endmodule
bind mpio_top mpio_props chk_i (.*);

/* dv/tb_mpio_top.sv */
// Testbench for mpio_top: register, pin and segment checks over APB.
// Assumes the board model mpio_pad and the offsets in mpio_defs.vh.
`include "mpio_defs.vh"
module tb_mpio_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 8'h00, seg_a_drive = 8'h00, seg_d_drive = 8'h00, ext_a = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, slow_crystal_en, ext_irq_latch;
  logic [7:0] port_a_in, port_a_out, port_a_oe, port_d_in, port_d_out, port_d_oe;
  logic [2:0] port_b_in, port_b_out, port_b_oe;
  logic [3:0] port_c_in, port_c_out, port_c_oe;
  int errors = 0, compares = 0;
  mpio_top uut (.*);
  mpio_pad #(8) pa (.out(port_a_out), .oe(port_a_oe), .ext_low(ext_a), .pin(port_a_in));
  mpio_pad #(3) pb (.out(port_b_out), .oe(port_b_oe), .ext_low(3'h0), .pin(port_b_in));
  mpio_pad #(4) pc (.out(port_c_out), .oe(port_c_oe), .ext_low(4'h0), .pin(port_c_in));
  mpio_pad #(8) pd (.out(port_d_out), .oe(port_d_oe), .ext_low(8'h00), .pin(port_d_in));
  // Clock and hang guard
  initial forever #2 pclk = ~pclk;
  initial begin
    #20000;
    errors++;
    results;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // One APB transfer; answer taken at the edge where pready is high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdv);
  endtask
  task settle;
    repeat (6) @(negedge pclk);
  endtask
  task results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd("a_latch", `MPIO_A_LATCH, 32'hFF);
    rd("a_seg", `MPIO_A_SEG, 32'h0);
    rd("b_latch", `MPIO_B_LATCH, 32'h7);
    rd("c_latch", `MPIO_C_LATCH, 32'hF);
    rd("c_type", `MPIO_C_TYPE, 32'h0);
    rd("d_latch", `MPIO_D_LATCH, 32'hFF);
    rd("d_seg", `MPIO_D_SEG, 32'h0);
    $display("test reset done");
    apb(1'b1, `MPIO_B_LATCH, 32'hFFFFFF02);
    rd("b_latch", `MPIO_B_LATCH, 32'h2);
    apb(1'b1, `MPIO_C_TYPE, 32'hFFFFFFF3);
    rd("c_type", `MPIO_C_TYPE, 32'h3);
    chk("okay", 32'h0, {31'h0, er});
    apb(1'b1, 8'hFC, 32'h1);
    chk("slverr", 32'h1, {31'h0, er});
    rd("unmapped", 8'hFC, 32'h0);
    apb(1'b1, `MPIO_B_LATCH, 32'h7);
    $display("test widths done");
    apb(1'b1, `MPIO_CTRL, 32'h5);
    seg_a_drive <= 8'h80;
    seg_d_drive <= 8'hA5;
    ext_a <= 8'h02;
    apb(1'b1, `MPIO_A_LATCH, 32'hDA);
    apb(1'b1, `MPIO_A_SEG, 32'h80);
    apb(1'b1, `MPIO_D_SEG, 32'h0F);
    apb(1'b1, `MPIO_C_LATCH, 32'h5);
    settle;
    chk("crystal", 32'h1, {31'h0, slow_crystal_en});
    chk("a_seg_pin", 32'h180, {23'h0, port_a_oe[7], port_a_out});
    chk("d_seg_pin", 32'h0F05, {16'h0, port_d_oe, port_d_out & 8'h0F});
    chk("c_oe", 32'hB, {28'h0, port_c_oe});
    rd("a_latch", `MPIO_A_LATCH, 32'hDA);
    rd("a_pin", `MPIO_A_PIN, 32'h58);
    rd("d_pin", `MPIO_D_PIN, 32'hF0);
    rd("c_pin", `MPIO_C_PIN, 32'h5);
    $display("test pins done");
    apb(1'b1, `MPIO_CTRL, 32'h4);
    apb(1'b1, `MPIO_B_LATCH, 32'h6);
    settle;
    chk("irq", 32'h1, {31'h0, ext_irq_latch});
    chk("b_drive", 32'h08, {26'h0, port_b_oe, port_b_out});
    rd("status", `MPIO_STAT, 32'h1);
    apb(1'b1, `MPIO_STAT, 32'h1);
    rd("status", `MPIO_STAT, 32'h0);
    chk("irq_clear", 32'h0, {31'h0, ext_irq_latch});
    $display("test interrupt done");
    apb(1'b1, `MPIO_CTRL, 32'h6);
    settle;
    chk("b_oe0", 32'h0, {31'h0, port_b_oe[0]});
    rd("b_pin", `MPIO_B_PIN, 32'h7);
    $display("test stop done");
    results;
  end
endmodule

/* src/mpio_defs.vh */
// Constants for the multi-port I/O block: APB register offsets, reset values, field positions.
// Assumes byte addressing with one aligned 32-bit word per register.
`ifndef MPIO_DEFS_VH
`define MPIO_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MPIO_A_LATCH 8'h00
`define MPIO_A_PIN 8'h04
`define MPIO_A_SEG 8'h08
`define MPIO_B_LATCH 8'h0C
`define MPIO_B_PIN 8'h10
`define MPIO_C_LATCH 8'h14
`define MPIO_C_PIN 8'h18
`define MPIO_C_TYPE 8'h1C
`define MPIO_D_LATCH 8'h20
`define MPIO_D_PIN 8'h24
`define MPIO_D_SEG 8'h28
`define MPIO_CTRL 8'h2C
`define MPIO_STAT 8'h30
// ----------------------------------------
// Reset values
// ----------------------------------------
`define MPIO_A_LATCH_RST 8'hFF
`define MPIO_A_SEG_RST 8'h00
`define MPIO_B_LATCH_RST 3'h7
`define MPIO_C_LATCH_RST 4'hF
`define MPIO_C_TYPE_RST 4'h0
`define MPIO_D_LATCH_RST 8'hFF
`define MPIO_D_SEG_RST 8'h00
`define MPIO_CTRL_RST 3'h0
// ----------------------------------------
// Control and status field positions
// ----------------------------------------
`define MPIO_CTRL_DUAL 0
`define MPIO_CTRL_STOP 1
`define MPIO_CTRL_GLOBAL_OE 2
`define MPIO_STAT_IRQ 0
`endif

/* src/mpio_top.v */
// Multi-port I/O: port_a segment select, port_b, port_c and port_d registers and pin drive.
// Assumes an APB master on pclk; pin inputs arrive asynchronously and are synchronised here.
// Each register is one aligned 32-bit word; undefined read bits return zero.
// Pins appear as separate out, oe and in vectors; a high oe drives the pin.
`include "mpio_defs.vh"
module mpio_top (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Segment drive from the display controller
  input wire [7:0] seg_a_drive,
  input wire [7:0] seg_d_drive,
  // Port pins (input, output, enable)
  input wire [7:0] port_a_in,
  output reg [7:0] port_a_out,
  output reg [7:0] port_a_oe,
  input wire [2:0] port_b_in,
  output reg [2:0] port_b_out,
  output reg [2:0] port_b_oe,
  input wire [3:0] port_c_in,
  output reg [3:0] port_c_out,
  output reg [3:0] port_c_oe,
  input wire [7:0] port_d_in,
  output reg [7:0] port_d_out,
  output reg [7:0] port_d_oe,
  // Crystal enable and interrupt latch
  output reg slow_crystal_en,
  output reg ext_irq_latch
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Latches, selects and control
  reg [7:0] a_latch_r;
  reg [7:0] a_seg_r;
  reg [2:0] b_latch_r;
  reg [3:0] c_latch_r;
  reg [3:0] c_type_r;
  reg [7:0] d_latch_r;
  reg [7:0] d_seg_r;
  reg [2:0] ctrl_r;
  reg irq_r;
  // Synchroniser stages and filtered pin levels
  reg [22:0] s1_r;
  reg [22:0] s2_r;
  reg [22:0] s3_r;
  reg [22:0] pin_r;
  // Delayed port_b bit 0 for edge detect
  reg b0_drv_r;
  // Bus strobes, mode bits and decode
  wire wr_en;
  wire rd_en;
  wire dual_mode;
  wire stop_mode;
  wire out_en;
  wire [22:0] raw_in;
  wire irq_set;
  wire irq_clr;
  reg [31:0] rd_mux;
  reg hit;

  // Writes land at the edge that completes the access, with pready high
  // Read data is captured one edge earlier so it stands with pready
  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;
  assign dual_mode = ctrl_r[`MPIO_CTRL_DUAL];
  assign stop_mode = ctrl_r[`MPIO_CTRL_STOP];
  assign out_en = ctrl_r[`MPIO_CTRL_GLOBAL_OE];
  assign raw_in = {port_d_in, port_c_in, port_b_in, port_a_in};

  // ----------------------------------------
  // Pin input synchroniser, change taken once stages two and three agree
  // ----------------------------------------
  // A level counts only when two stages agree, so a value caught
  // mid-change in the first stage never reaches the read mux
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 23'h000000;
      s2_r <= 23'h000000;
      s3_r <= 23'h000000;
      pin_r <= 23'h000000;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));
    end
  end

  // ----------------------------------------
  // Register writes, one process per register
  // ----------------------------------------
  // port_a output latch; ones leave the open-drain pins floating
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      a_latch_r <= `MPIO_A_LATCH_RST;
    else if (wr_en && (paddr == `MPIO_A_LATCH))
      a_latch_r <= pwdata[7:0];
  end

  // port_a segment select, cleared so every pin starts as plain I/O
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      a_seg_r <= `MPIO_A_SEG_RST;
    else if (wr_en && (paddr == `MPIO_A_SEG))
      a_seg_r <= pwdata[7:0];
  end

  // port_b output latch, three bits; upper write data dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      b_latch_r <= `MPIO_B_LATCH_RST;
    else if (wr_en && (paddr == `MPIO_B_LATCH))
      b_latch_r <= pwdata[2:0];
  end

  // port_c output latch, four bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      c_latch_r <= `MPIO_C_LATCH_RST;
    else if (wr_en && (paddr == `MPIO_C_LATCH))
      c_latch_r <= pwdata[3:0];
  end

  // port_c output type, open drain after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      c_type_r <= `MPIO_C_TYPE_RST;
    else if (wr_en && (paddr == `MPIO_C_TYPE))
      c_type_r <= pwdata[3:0];
  end

  // port_d output latch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      d_latch_r <= `MPIO_D_LATCH_RST;
    else if (wr_en && (paddr == `MPIO_D_LATCH))
      d_latch_r <= pwdata[7:0];
  end

  // port_d segment select
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      d_seg_r <= `MPIO_D_SEG_RST;
    else if (wr_en && (paddr == `MPIO_D_SEG))
      d_seg_r <= pwdata[7:0];
  end

  // Control: dual clock, stop mode, global output enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_r <= `MPIO_CTRL_RST;
    else if (wr_en && (paddr == `MPIO_CTRL))
      ctrl_r <= pwdata[2:0];
  end

  // ----------------------------------------
  // Interrupt latch on falling edge of driven port_b pin 0
  // ----------------------------------------
  // Set term: bit 0 was one last cycle, is zero now, and the pin is driven
  assign irq_set = b0_drv_r & ~b_latch_r[0] & ~stop_mode & out_en;
  assign irq_clr = wr_en & (paddr == `MPIO_STAT) & pwdata[`MPIO_STAT_IRQ];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b0_drv_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      b0_drv_r <= b_latch_r[0];
      if (irq_set)
        irq_r <= 1'b1; // Set wins over clear
      else if (irq_clr)
        irq_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read mux, latches and pin levels at separate offsets
  // ----------------------------------------
  // Unimplemented and undefined read bits return zero
  always @* begin
    rd_mux = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      `MPIO_A_LATCH: rd_mux[7:0] = a_latch_r;
      `MPIO_A_PIN: rd_mux[7:0] = pin_r[7:0] & ~a_seg_r;
      `MPIO_A_SEG: rd_mux[7:0] = a_seg_r;
      `MPIO_B_LATCH: rd_mux[2:0] = b_latch_r;
      `MPIO_B_PIN: rd_mux[2:0] = pin_r[10:8];
      `MPIO_C_LATCH: rd_mux[3:0] = c_latch_r;
      `MPIO_C_PIN: rd_mux[3:0] = pin_r[14:11];
      `MPIO_C_TYPE: rd_mux[3:0] = c_type_r;
      `MPIO_D_LATCH: rd_mux[7:0] = d_latch_r;
      `MPIO_D_PIN: rd_mux[7:0] = pin_r[22:15] & ~d_seg_r;
      `MPIO_D_SEG: rd_mux[7:0] = d_seg_r;
      `MPIO_CTRL: rd_mux[2:0] = ctrl_r;
      `MPIO_STAT: rd_mux[0] = irq_r;
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // APB answer, one wait state
  // ----------------------------------------
  // pready rises one cycle after penable; pslverr marks unmapped offsets
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata <= rd_en ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // port_a: segment bits follow the display drive, others sink when latch is low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_out <= 8'h00;
      port_a_oe <= 8'h00;
    end else begin
      port_a_out <= a_seg_r & seg_a_drive;
      port_a_oe <= out_en ? (a_seg_r | ~a_latch_r) : 8'h00;
    end
  end

  // port_b: open drain; crystal pins and the stop-release pin can be forced to float
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_out <= 3'h0;
      port_b_oe <= 3'h0;
    end else begin
      port_b_out <= 3'h0;
      port_b_oe <= out_en ? ~b_latch_r : 3'h0;
      // Later assignments override the latch-driven enable
      if (dual_mode)
        port_b_oe[2:1] <= 2'b00;
      if (stop_mode)
        port_b_oe[0] <= 1'b0;
    end
  end

  // port_c: type 0 sinks only, type 1 drives both levels
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_c_out <= 4'h0;
      port_c_oe <= 4'h0;
    end else begin
      port_c_out <= c_latch_r;
      port_c_oe <= out_en ? (c_type_r | ~c_latch_r) : 4'h0;
    end
  end

  // port_d: segment bits follow the display drive, others open drain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_d_out <= 8'h00;
      port_d_oe <= 8'h00;
    end else begin
      port_d_out <= d_seg_r & seg_d_drive;
      port_d_oe <= out_en ? (d_seg_r | ~d_latch_r) : 8'h00;
    end
  end

  // Crystal enable and interrupt latch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_crystal_en <= 1'b0;
      ext_irq_latch <= 1'b0;
    end else begin
      slow_crystal_en <= dual_mode;
      ext_irq_latch <= irq_set | irq_r;
    end
  end
endmodule
